// >>> bench/eeprom_props.sv
// Concurrent checks on the two-wire link between the master and the EEPROM slave.
`timescale 1ns/100ps
module eeprom_props
#(
	parameter int unsigned WRITE_CYCLES = 2000
)
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic scl,
	input wire logic sda,
	input wire logic dev_sda_oe,
	input wire logic write_busy,
	input wire logic supply_low
);
	logic        prev_scl;
	logic        prev_sda;
	logic        busy_seen;
	logic [3:0]  nbits;
	logic [7:0]  ctrl;
	logic [5:0]  since_stop;
	int unsigned busy_len;

	// Bit count and first byte since the last Start; the count saturates so data bytes never alias.
	always_ff @(posedge sys_clk)
	begin
		prev_scl <= scl;
		prev_sda <= sda;
		if (reset || (scl && prev_scl && prev_sda && !sda))
		begin
			nbits     <= 4'h0;
			busy_seen <= write_busy;
		end
		else
		begin
			busy_seen <= busy_seen | write_busy;
			if (scl && !prev_scl && nbits != 4'hf)
				nbits <= nbits + 4'h1;
			if (scl && !prev_scl && nbits < 4'h8)
				ctrl <= {ctrl[6:0], sda};
		end
	end

	// Length of the running write cycle and time since the last Stop.
	always_ff @(posedge sys_clk)
	begin
		if (reset || !write_busy)
			busy_len <= 0;
		else
			busy_len <= busy_len + 1;
		if (reset || (scl && prev_scl && !prev_sda && sda))
			since_stop <= 6'h0;
		else if (since_stop != 6'h3f)
			since_stop <= since_stop + 6'h1;
	end

	sequence ack_slot;
		$rose(scl) && nbits == 4'h8;
	endsequence
	sequence stop_cond;
		scl && $rose(sda);
	endsequence

	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);

	a_ctrl_quiet: assert property (nbits < 4'h8 |-> !dev_sda_oe)
		else $error("slave drove sda inside a control byte");
	a_code_refused: assert property ((ack_slot ##0 ctrl[7:4] != 4'ha) |-> sda)
		else $error("slave acknowledged a foreign type code");
	a_code_acked: assert property ((ack_slot ##0 (ctrl[7:4] == 4'ha && !busy_seen)) |-> !sda)
		else $error("slave missed the control byte acknowledge");
	a_busy_quiet: assert property (write_busy |-> !dev_sda_oe)
		else $error("slave drove sda during a write cycle");
	a_busy_bounded: assert property (write_busy |-> busy_len < WRITE_CYCLES)
		else $error("write cycle ran too long");
	a_busy_after_stop: assert property ($rose(write_busy) |-> since_stop <= 6'h10)
		else $error("write cycle began without a Stop");
	a_supply_inhibit: assert property ($rose(write_busy) |-> !supply_low && !$past(supply_low, 8))
		else $error("programming began on low supply");
	a_stop_release: assert property (stop_cond |-> !dev_sda_oe [*4])
		else $error("slave drove sda after a Stop");
	a_hold_scl_low: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("slave changed sda while scl was high");
endmodule // eeprom_props

// >>> bench/serial_eeprom_i2c_slave_tb.sv
// Self-checking bench: the master and the EEPROM slave joined over the two-wire link.
`timescale 1ns/100ps
`include "eeprom_regs.svh"
module serial_eeprom_i2c_slave_tb
	import eeprom_pkg::*;
;
	localparam int unsigned WCYC = 2000;
	logic        sys_clk = 1'b0;
	logic        reset = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dat_w = 32'h0;
	logic [31:0] dat_r;
	logic        ack;
	logic        want = 1'b0;
	logic        write_protect = 1'b0;
	logic        supply_low = 1'b0;
	logic        write_busy;
	logic [31:0] rdata;
	byte_t       mem [512];
	byte_t       expq [$];
	int          mismatches = 0;
	int          n_checks = 0;
	int          seed = 49;

	// Short write cycle keeps the run brief while polling still meets a busy slave.
	twi_if twi_if_i ();
	eeprom_slave #(.WRITE_CYCLES(WCYC)) eeprom_slave_i (.sys_clk(sys_clk), .reset(reset),
		.bus(twi_if_i.device), .write_protect(write_protect), .supply_low(supply_low),
		.write_busy(write_busy));
	twi_master twi_master_i (.sys_clk(sys_clk), .reset(reset), .bus(twi_if_i.host),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack));
	eeprom_props #(.WRITE_CYCLES(WCYC)) eeprom_props_i (.sys_clk(sys_clk), .reset(reset),
		.scl(twi_if_i.scl), .sda(twi_if_i.sda), .dev_sda_oe(twi_if_i.dev_sda_oe),
		.write_busy(write_busy), .supply_low(supply_low));

	// Clock of 20 ns.
	always #10 sys_clk = ~sys_clk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Each noted read is compared at the edge where its acknowledge is sampled.
	always @(posedge sys_clk)
		if (ack === 1'b1 && want)
			check(dat_r, {24'h0, expq.pop_front()});

	// One classic cycle; the request is held until ack is seen, a hang ends the run.
	task automatic wb(input logic w, input logic [7:0] a, input byte_t d, input logic chk);
		int n;
		n = 0;
		@(posedge sys_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_w <= {24'h0, d};
		want <= chk;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (ack !== 1'b1 && n < 100);
		if (ack !== 1'b1)
			mismatches++;
		if (ack !== 1'b1)
			stop_test();
		rdata = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		want <= 1'b0;
	endtask

	// Issues a link command and waits, bounded, for the master to go idle.
	task automatic op(input logic [2:0] c, input byte_t d);
		int n;
		if (c == `CMD_WRITE)
			wb(1'b1, `ADR_TXD, d, 1'b0);
		wb(1'b1, `ADR_CMD, {5'h0, c}, 1'b0);
		for (n = 0; n < 1000 && rdata[`STATUS_BUSY_BIT] !== 1'b0 || n == 0; n++)
			wb(1'b0, `ADR_STATUS, 8'h00, 1'b0);
		if (n >= 1000)
			mismatches++;
		if (n >= 1000)
			stop_test();
	endtask

	task automatic send(input byte_t d, input logic nack);
		op(`CMD_WRITE, d);
		expq.push_back({6'h0, nack, 1'b0});
		wb(1'b0, `ADR_STATUS, 8'h00, 1'b1);
	endtask

	task automatic recv(input logic more, input byte_t exp);
		op(more ? `CMD_READ_ACK : `CMD_READ_NACK, 8'h00);
		expq.push_back(exp);
		wb(1'b0, `ADR_RXD, 8'h00, 1'b1);
	endtask

	// Counts refused write control bytes before the slave answers again.
	task automatic poll(output int nacks);
		logic nk;
		nacks = -1;
		do
		begin
			op(`CMD_START, 8'h00);
			op(`CMD_WRITE, 8'ha0);
			wb(1'b0, `ADR_STATUS, 8'h00, 1'b0);
			nk = rdata[`STATUS_NACK_BIT];
			op(`CMD_STOP, 8'h00);
			nacks++;
		end
		while (nk !== 1'b0 && nacks < 20);
	endtask

	// Writes n random bytes from address a; the model follows only when programming is allowed.
	task automatic wr(input logic [8:0] a, input int n, input logic prog);
		byte_t d;
		int    k;
		op(`CMD_START, 8'h00);
		send({4'ha, 2'b00, a[8], 1'b0}, 1'b0);
		send(a[7:0], 1'b0);
		for (k = 0; k < n; k++)
		begin
			d = byte_t'($random(seed));
			send(d, 1'b0);
			if (prog)
				mem[{a[8:4], a[3:0] + k[3:0]}] = d;
		end
		op(`CMD_STOP, 8'h00);
		poll(k);
		check({31'h0, prog ? (k > 0 && k < 4) : (k == 0)}, 32'h1);
	endtask

	// Random read of n bytes from address a, acknowledging all but the last.
	task automatic rd(input logic [8:0] a, input int n);
		int k;
		op(`CMD_START, 8'h00);
		send({4'ha, 2'b00, a[8], 1'b0}, 1'b0);
		send(a[7:0], 1'b0);
		op(`CMD_START, 8'h00);
		send({4'ha, 2'b00, a[8], 1'b1}, 1'b0);
		for (k = 0; k < n; k++)
			recv(k != n - 1, mem[a + k[8:0]]);
		op(`CMD_STOP, 8'h00);
	endtask

	initial
	begin
		byte_t bad;
		int    k;
		repeat (20) @(posedge sys_clk);
		reset <= 1'b0;
		repeat (6) @(posedge sys_clk);
		for (k = 0; k < 2; k++)
		begin
			bad = byte_t'($random(seed));
			bad[7:4] = (bad[7:4] == 4'ha) ? 4'h5 : bad[7:4];
			op(`CMD_START, 8'h00);
			send(bad, 1'b1);
			op(`CMD_STOP, 8'h00);
		end
		$display("test foreign codes done");
		wr(9'h1f8, 18, 1'b1);
		wr(9'h000, 3, 1'b1);
		$display("test page writes done");
		write_protect <= 1'b1;
		wr(9'h1ff, 1, 1'b0);
		wr(9'h001, 1, 1'b1);
		supply_low <= 1'b1;
		wr(9'h002, 1, 1'b0);
		supply_low <= 1'b0;
		$display("test protection done");
		rd(9'h1fe, 4);
		op(`CMD_START, 8'h00);
		send(8'ha1, 1'b0);
		recv(1'b0, mem[9'h002]);
		op(`CMD_STOP, 8'h00);
		$display("test reads done");
		stop_test();
	end
endmodule // serial_eeprom_i2c_slave_tb

// >>> rtl/eeprom_slave.sv
// Two-wire slave end of a 4 Kbit serial EEPROM with page buffer and write protect.
//
// Our own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "eeprom_regs.svh"
module eeprom_slave
	import eeprom_pkg::*;
#(
	parameter int unsigned WRITE_CYCLES = `TWC_CYCLES
)
(
	input  wire logic sys_clk,
	input  wire logic reset,
	twi_if.device     bus,
	input  wire logic write_protect,
	input  wire logic supply_low,
	output logic      write_busy
);
	logic [3:0]  pins;
	logic        scl_now;
	logic        sda_now;
	logic        wp_now;
	logic        low_now;
	logic        scl_prev;
	logic        sda_prev;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_seen;
	logic        stop_seen;
	logic        commit;
	logic        code_ok;

	dev_state_e  state;
	logic [3:0]  cnt;
	byte_t       shreg;
	byte_t       txd;
	byte_t       rd_byte;
	mem_addr_t   ptr;
	logic        read_op;
	logic        master_ack;
	logic [31:0] wcnt;

	byte_t       mem [`MEM_BYTES];
	byte_t       pbuf [`PAGE_BYTES];
	logic [`PAGE_BYTES-1:0] pvalid;

	// Both link lines and both static inputs arrive from outside this clock domain.
	pin_sync #(.WIDTH(4)) u_sync
	(
		.sys_clk (sys_clk),
		.reset   (reset),
		.raw     ({bus.scl, bus.sda, write_protect, supply_low}),
		.level   (pins)
	);

	assign scl_now = pins[3];
	assign sda_now = pins[2];
	assign wp_now  = pins[1];
	assign low_now = pins[0];

	// Remember the filtered levels so edges and bus conditions can be found.
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end
		else
		begin
			scl_prev <= scl_now;
			sda_prev <= sda_now;
		end
	end

	// Start and Stop are data edges while the clock stays high.
	assign scl_rise   = scl_now & ~scl_prev;
	assign scl_fall   = ~scl_now & scl_prev;
	assign start_seen = scl_now & scl_prev & sda_prev & ~sda_now;
	assign stop_seen  = scl_now & scl_prev & ~sda_prev & sda_now;

	// The upper four bits must carry the device type; a busy device answers nothing.
	assign code_ok = (shreg[7:4] == `DEVICE_CODE) & ~write_busy;

	// Read data comes straight from the array; protection plays no part here.
	assign rd_byte = mem[ptr];

	// Program only a buffered write ended by Stop, outside the protected half, on good supply.
	assign commit = stop_seen & (state == st_wdata) & (|pvalid)
		& ~(wp_now & ptr[8])
		& ~low_now;

	// Link protocol: receive on rising clock edges, drive the data line after falling ones.
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			state      <= st_idle;
			cnt        <= 4'h0;
			shreg      <= 8'h00;
			txd        <= 8'h00;
			ptr        <= 9'h000;
			read_op    <= 1'b0;
			master_ack <= 1'b0;
			pvalid     <= '0;
			bus.dev_sda_oe <= 1'b0;
		end
		else if (start_seen)
		begin
			// A repeated Start keeps the pointer but throws away unprogrammed bytes.
			state  <= st_ctrl;
			// The clock fall that closes the Start carries no bit, so count from one below zero.
			cnt    <= 4'hf;
			pvalid <= '0;
			bus.dev_sda_oe <= 1'b0;
		end
		else if (stop_seen)
		begin
			state  <= st_idle;
			pvalid <= '0;
			bus.dev_sda_oe <= 1'b0;
		end
		else if (scl_rise)
		begin
			if (state == st_rdata)
			begin
				if (cnt == 4'd8)
					master_ack <= ~sda_now;
			end
			else if (cnt != 4'd8)
				shreg <= {shreg[6:0], sda_now};
		end
		else if (scl_fall)
		begin
			unique case (state)
				st_idle:
				begin
					cnt <= 4'h0;
				end
				st_ctrl:
				begin
					if (cnt == 4'd7)
					begin
						if (code_ok)
						begin
							bus.dev_sda_oe <= 1'b1;
							cnt      <= 4'd8;
							read_op  <= shreg[0];
							ptr[8]   <= shreg[1];
						end
						else
							state <= st_idle;
					end
					else if (cnt == 4'd8)
					begin
						cnt <= 4'h0;
						if (read_op)
						begin
							state <= st_rdata;
							txd   <= rd_byte;
							bus.dev_sda_oe <= ~rd_byte[7];
						end
						else
						begin
							state <= st_addr;
							bus.dev_sda_oe <= 1'b0;
						end
					end
					else
						cnt <= cnt + 4'd1;
				end
				st_addr:
				begin
					if (cnt == 4'd7)
					begin
						ptr[7:0] <= shreg;
						bus.dev_sda_oe <= 1'b1;
						cnt      <= 4'd8;
					end
					else if (cnt == 4'd8)
					begin
						state <= st_wdata;
						bus.dev_sda_oe <= 1'b0;
						cnt   <= 4'h0;
					end
					else
						cnt <= cnt + 4'd1;
				end
				st_wdata:
				begin
					if (cnt == 4'd7)
					begin
						// Bytes past sixteen wrap within the page onto filled slots and replace earlier ones.
						pbuf[ptr[3:0]]   <= shreg;
						pvalid[ptr[3:0]] <= 1'b1;
						ptr[3:0] <= ptr[3:0] + 4'd1;
						bus.dev_sda_oe <= 1'b1;
						cnt      <= 4'd8;
					end
					else if (cnt == 4'd8)
					begin
						bus.dev_sda_oe <= 1'b0;
						cnt <= 4'h0;
					end
					else
						cnt <= cnt + 4'd1;
				end
				st_rdata:
				begin
					if (cnt == 4'd7)
					begin
						// The whole nine-bit pointer steps, wrapping from the top to zero.
						bus.dev_sda_oe <= 1'b0;
						ptr <= ptr + 9'h001;
						cnt <= 4'd8;
					end
					else if (cnt == 4'd8)
					begin
						cnt <= 4'h0;
						if (master_ack)
						begin
							txd <= rd_byte;
							bus.dev_sda_oe <= ~rd_byte[7];
						end
						else
							state <= st_idle;
					end
					else
					begin
						bus.dev_sda_oe <= ~txd[6];
						txd <= {txd[6:0], 1'b0};
						cnt <= cnt + 4'd1;
					end
				end
			endcase
		end
	end

	// The open-drain driver only ever pulls low.
	always_ff @(posedge sys_clk)
	begin
		bus.dev_sda_out <= 1'b0;
	end

	// Buffered bytes go into the array at the start of the cycle; the timer then models its length.
	always_ff @(posedge sys_clk)
	begin
		if (commit)
		begin
			for (int i = 0; i < `PAGE_BYTES; i++)
			begin
				if (pvalid[i])
					mem[{ptr[8:4], 4'(i)}] <= pbuf[i];
			end
		end
	end

	// Self-timed write cycle: busy for a fixed count that stays inside the five millisecond ceiling.
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			write_busy <= 1'b0;
			wcnt       <= 32'h0;
		end
		else if (commit)
		begin
			write_busy <= 1'b1;
			wcnt       <= WRITE_CYCLES - 32'd1;
		end
		else if (write_busy)
		begin
			if (wcnt == 32'h0)
				write_busy <= 1'b0;
			else
				wcnt <= wcnt - 32'd1;
		end
	end
endmodule // eeprom_slave

// >>> rtl/pin_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous pins.
`timescale 1ns/100ps
module pin_sync
#(
	parameter int WIDTH = 2
)
(
	input  wire logic             sys_clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] raw,
	output logic      [WIDTH-1:0] level
);
	logic [WIDTH-1:0] s1;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;

	// Idle lines read high, so the filtered level starts high too.
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			s1    <= '1;
			s2    <= '1;
			s3    <= '1;
			level <= '1;
		end
		else
		begin
			s1 <= raw;
			s2 <= s1;
			s3 <= s2;
			// A change is accepted only once two stages agree, which drops one-cycle glitches.
			for (int i = 0; i < WIDTH; i++)
			begin
				if (s2[i] == s3[i])
					level[i] <= s3[i];
			end
		end
	end
endmodule // pin_sync

// >>> rtl/twi_master.sv
// Two-wire bus master driven by byte-level commands over a classic Wishbone slave.
`timescale 1ns/100ps
`include "eeprom_regs.svh"
module twi_master
	import eeprom_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        reset,
	twi_if.host              bus,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o
);
	logic [1:0]  pins;
	logic        sda_now;
	logic        wb_req;
	logic        wb_wr;
	logic        cmd_wr;
	host_state_e state;
	logic [1:0]  phase;
	logic [7:0]  qcnt;
	logic        tick;
	logic [3:0]  bitn;
	logic        rd;
	logic        send_nack;
	byte_t       sh;
	byte_t       txd;
	byte_t       rxd;
	logic        nack_rx;

	pin_sync #(.WIDTH(2)) u_sync
	(
		.sys_clk (sys_clk),
		.reset   (reset),
		.raw     ({bus.scl, bus.sda}),
		.level   (pins)
	);

	assign sda_now = pins[0];

	// One-cycle answer; a write lands only at the edge where the master samples ack high,
	// so a master that abandons the cycle early changes nothing.
	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wb_wr  = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
	assign cmd_wr = wb_wr & (wb_adr_i == `ADR_CMD) & (state == h_idle);

	always_ff @(posedge sys_clk)
	begin
		if (reset)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wb_req;
	end

	// Read mux; unmapped offsets read as zero.
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			wb_dat_o <= 32'h0;
		else if (wb_req)
		begin
			unique case (wb_adr_i)
				`ADR_STATUS: wb_dat_o <= {30'h0, nack_rx, state != h_idle};
				`ADR_TXD:    wb_dat_o <= {24'h0, txd};
				`ADR_RXD:    wb_dat_o <= {24'h0, rxd};
				default:     wb_dat_o <= 32'h0;
			endcase
		end
	end

	// Transmit byte register.
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			txd <= 8'h00;
		else if (wb_wr & (wb_adr_i == `ADR_TXD))
			txd <= wb_dat_i[7:0];
	end

	// Quarter-period enable from a divider; each bit of the link takes four of them.
	assign tick = (qcnt == 8'h00);

	always_ff @(posedge sys_clk)
	begin
		if (reset || state == h_idle || tick)
			qcnt <= 8'(`SCL_QUARTER_CYCLES - 1);
		else
			qcnt <= qcnt - 8'h01;
	end

	// Sequencer: the master makes the serial clock and every Start and Stop.
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			state     <= h_idle;
			phase     <= 2'h0;
			bitn      <= 4'h0;
			rd        <= 1'b0;
			send_nack <= 1'b0;
			sh        <= 8'h00;
			rxd       <= 8'h00;
			nack_rx   <= 1'b0;
			bus.host_scl_oe <= 1'b0;
			bus.host_sda_oe <= 1'b0;
		end
		else if (cmd_wr)
		begin
			phase     <= 2'h0;
			bitn      <= 4'h0;
			sh        <= txd;
			rd        <= (wb_dat_i[2:0] == `CMD_READ_ACK) | (wb_dat_i[2:0] == `CMD_READ_NACK);
			send_nack <= (wb_dat_i[2:0] == `CMD_READ_NACK);
			unique case (wb_dat_i[2:0])
				`CMD_START:                        state <= h_start;
				`CMD_STOP:                         state <= h_stop;
				`CMD_WRITE, `CMD_READ_ACK, `CMD_READ_NACK: state <= h_byte;
				default:                           state <= h_idle;
			endcase
		end
		else if (tick && state != h_idle)
		begin
			phase <= phase + 2'h1;
			unique case (state)
				h_start:
				begin
					// Data falls while the clock is high, then the clock is pulled low.
					unique case (phase)
						2'h0: bus.host_sda_oe <= 1'b0;
						2'h1: bus.host_scl_oe <= 1'b0;
						2'h2: bus.host_sda_oe <= 1'b1;
						2'h3:
						begin
							bus.host_scl_oe <= 1'b1;
							state <= h_idle;
						end
					endcase
				end
				h_stop:
				begin
					unique case (phase)
						2'h0: bus.host_sda_oe <= 1'b1;
						2'h1: bus.host_scl_oe <= 1'b0;
						2'h2: bus.host_sda_oe <= 1'b0;
						2'h3: state <= h_idle;
					endcase
				end
				default:
				begin
					unique case (phase)
						2'h0:
						begin
							if (bitn == 4'd8)
								bus.host_sda_oe <= rd & ~send_nack;
							else
								bus.host_sda_oe <= ~rd & ~sh[7];
						end
						2'h1: bus.host_scl_oe <= 1'b0;
						2'h2:
						begin
							if (bitn == 4'd8)
							begin
								if (!rd)
									nack_rx <= sda_now;
							end
							else
								sh <= {sh[6:0], sda_now};
						end
						2'h3:
						begin
							bus.host_scl_oe <= 1'b1;
							if (bitn == 4'd8)
							begin
								if (rd)
									rxd <= sh;
								state <= h_idle;
							end
							else
								bitn <= bitn + 4'd1;
						end
					endcase
				end
			endcase
		end
	end

	// Open-drain drivers only ever pull low.
	always_ff @(posedge sys_clk)
	begin
		bus.host_scl_out <= 1'b0;
		bus.host_sda_out <= 1'b0;
	end
endmodule // twi_master

// >>> shared/eeprom_pkg.sv
// Types shared by the EEPROM slave and the bus master.
package eeprom_pkg;

	typedef logic [7:0] byte_t;
	typedef logic [8:0] mem_addr_t;

	typedef enum logic [2:0] {st_idle, st_ctrl, st_addr, st_wdata, st_rdata} dev_state_e;
	typedef enum logic [1:0] {h_idle, h_start, h_stop, h_byte} host_state_e;

endpackage

// >>> shared/eeprom_regs.svh
// Constants for the two-wire serial EEPROM slave and its bus master.
// Operation
// - Control byte starts with type code 1010.
// - Lowest block bit is address bit eight.
// - Last control bit: one reads, zero writes.
// - Acknowledge control byte only on matching code.
// - Write: acknowledge control, then load word address.
// - Byte write; Stop starts the self-timed cycle.
// - Up to sixteen bytes buffered, programmed at Stop.
// - Only low four pointer bits step on writes.
// - Extra bytes roll over and replace buffered ones.
// - Master keeps page writes inside one page; the bench sends 18 bytes from 1F8h, which roll over.
// - No acknowledge while busy; polling finds cycle end.
// - Protect input high blocks programming of 100h-1FFh.
// - Pointer holds last address plus one.
// - Read sends byte; no acknowledge then Stop ends.
// - Repeated Start keeps pointer, drops pending write.
// - Master acknowledge asks for next sequential byte.
// - Sequential reads step across the whole array.
// - Low supply inhibits all programming.
// - Write cycle lasts at most five milliseconds.
// - Protection never affects reads.
`ifndef EEPROM_REGS_SVH
`define EEPROM_REGS_SVH

`define CLK_HZ            50000000
`define CLK_PERIOD_NS     20
`define DEVICE_CODE       4'ha
`define MEM_BYTES         512
`define PAGE_BYTES        16
`define TWC_MS            5
`define TWC_CYCLES        ((`TWC_MS * `CLK_HZ) / 1000)
`define SCL_PERIOD_NS     2500
`define SCL_QUARTER_CYCLES \
	((`SCL_PERIOD_NS + 4 * `CLK_PERIOD_NS - 1) / (4 * `CLK_PERIOD_NS))

`define ADR_CMD           8'h00
`define ADR_STATUS        8'h04
`define ADR_TXD           8'h08
`define ADR_RXD           8'h0c
`define STATUS_BUSY_BIT   0
`define STATUS_NACK_BIT   1

`define CMD_START         3'h1
`define CMD_STOP          3'h2
`define CMD_WRITE         3'h3
`define CMD_READ_ACK      3'h4
`define CMD_READ_NACK     3'h5

`endif

// >>> shared/twi_if.sv
// Open-drain two-wire link between the bus master and the EEPROM slave.
`timescale 1ns/100ps
interface twi_if;
	logic scl;
	logic sda;
	logic host_scl_out;
	logic host_scl_oe;
	logic host_sda_out;
	logic host_sda_oe;
	logic dev_sda_out;
	logic dev_sda_oe;

	// Wired-AND with pull-ups: any enabled low driver pulls the line down.
	assign scl = (host_scl_oe & ~host_scl_out) ? 1'b0 : 1'b1;
	assign sda = ((host_sda_oe & ~host_sda_out) | (dev_sda_oe & ~dev_sda_out)) ? 1'b0 : 1'b1;

	modport device
	(
		input  scl,
		input  sda,
		output dev_sda_out,
		output dev_sda_oe
	);

	modport host
	(
		input  scl,
		input  sda,
		output host_scl_out,
		output host_scl_oe,
		output host_sda_out,
		output host_sda_oe
	);
endinterface
